/* include/hco_pkg.sv */
package hco_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] ADDR_CTRL = 32'hB000_806C;
  localparam logic [31:0] ADDR_POS = 32'hB000_8070;
  localparam logic [31:0] ADDR_WB = 32'hB000_8074;
  localparam logic [31:0] ADDR_BASE = 32'hB000_8078;
  localparam logic [31:0] ADDR_COL0 = 32'hB000_807C;
  localparam logic [31:0] ADDR_COL1 = 32'hB000_8080;
  localparam logic [31:0] ADDR_COL2 = 32'hB000_8084;
  localparam logic [31:0] ADDR_COL3 = 32'hB000_8088;
  localparam logic [31:0] ADDR_STATUS = 32'hB000_808C;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ****************************************************************
  // field layouts
  // ****************************************************************
  localparam logic [31:0] CTRL_MASK = 32'h07FF_07FF;
  localparam logic [31:0] POS_MASK = 32'h07FF_07FF;
  localparam logic [31:0] WB_MASK = 32'h07FF_07FF;
  localparam logic [31:0] COL_MASK = 32'h00FF_FFFF;
  localparam int MODE_LSB = 0;
  localparam int COLF_LSB = 0;
  localparam int ROWF_LSB = 16;
  localparam int FIELD_W = 11;

  // ****************************************************************
  // cursor formats
  // ****************************************************************
  localparam logic [2:0] MODE_32_4C = 3'h0;
  localparam logic [2:0] MODE_32_3T = 3'h1;
  localparam logic [2:0] MODE_64_4C = 3'h2;
  localparam logic [2:0] MODE_64_3T = 3'h3;
  localparam logic [2:0] MODE_128_2C = 3'h4;
  localparam logic [2:0] MODE_128_1T = 3'h5;
  localparam logic [11:0] SIDE_32 = 12'h020;
  localparam logic [11:0] SIDE_64 = 12'h040;
  localparam logic [11:0] SIDE_128 = 12'h080;
  localparam logic [1:0] CODE_TRANS_2BPP = 2'h3;
  localparam logic [1:0] CODE_TRANS_1BPP = 2'h0;

  // ****************************************************************
  // fetch
  // ****************************************************************
  localparam int BUF_WORDS = 8;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } hco_rgb_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } hco_apb_req_s;

  typedef enum logic {FETCH_IDLE, FETCH_RUN} hco_fetch_e;

endpackage : hco_pkg

/* design/hco_palette.sv */
`timescale 1ns/1ns
`default_nettype none
module hco_palette (
  input wire logic [2:0] i_mode,
  input wire logic [1:0] i_code,
  input wire hco_pkg::hco_rgb_s [3:0] i_colours,
  output hco_pkg::hco_rgb_s o_rgb,
  output logic o_opaque
);
  import hco_pkg::*;

  wire mode_legal = (i_mode <= MODE_128_1T);
  wire trans_mode = (i_mode == MODE_32_3T) || (i_mode == MODE_64_3T) ||
                    (i_mode == MODE_128_1T);
  wire trans_code = (i_mode == MODE_128_1T) ? (i_code == CODE_TRANS_1BPP) :
                    (i_code == CODE_TRANS_2BPP);

  // pixel value n picks colour register n
  assign o_rgb = i_colours[i_code];
  // colour three never shows in the 2bpp transparency modes; MODE_128_1T hides colour zero
  assign o_opaque = mode_legal && !(trans_mode && trans_code);

endmodule : hco_palette
`default_nettype wire

/* design/hco_cursor.sv */
// Functional notes
// - mode field picks one of six bitmap formats
// - block side 32, 64 or 128 by mode
// - bitmap tip offset X and Y held
// - screen tip position writable at any time
// - fetch length words per cursor line
// - line address advances by word stride
// - fetch starts at cursor base address
// - pixel value n shows colour register n
// - colour three ignored in the 2bpp transparency modes, colour zero in MODE_128_1T
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module hco_cursor (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire hco_pkg::hco_apb_req_s I_APB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_LINE_START,
  input wire logic [10:0] I_LINE_Y,
  input wire logic I_PIX_VALID,
  input wire logic [10:0] I_PIX_X,
  input wire hco_pkg::hco_rgb_s I_VIDEO_RGB,
  output hco_pkg::hco_rgb_s O_PIX_RGB,
  output logic O_PIX_VALID,
  output logic O_CURSOR_HIT,
  output logic O_MEM_REQ,
  output logic [31:0] O_MEM_ADDR,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA
);
  import hco_pkg::*;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic [31:0] ctrl_q, pos_q, wb_q, base_q;
  logic [3:0][31:0] col_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  wire [31:0] paddr = I_APB.paddr;
  wire access = I_APB.psel && I_APB.penable;
  wire commit = access && pready_q;
  wire wr_en = commit && I_APB.pwrite;
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_pos = (paddr == ADDR_POS);
  wire sel_wb = (paddr == ADDR_WB);
  wire sel_base = (paddr == ADDR_BASE);
  wire sel_status = (paddr == ADDR_STATUS);
  wire [3:0] sel_col = {paddr == ADDR_COL3, paddr == ADDR_COL2,
                        paddr == ADDR_COL1, paddr == ADDR_COL0};
  wire mapped = sel_ctrl || sel_pos || sel_wb || sel_base || sel_status ||
                (|sel_col);
  wire [31:0] status_word;
  wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                       sel_pos ? pos_q :
                       sel_wb ? wb_q :
                       sel_base ? base_q :
                       sel_col[0] ? col_q[0] :
                       sel_col[1] ? col_q[1] :
                       sel_col[2] ? col_q[2] :
                       sel_col[3] ? col_q[3] :
                       sel_status ? status_word : RESET_VALUE;
  // one wait state keeps prdata and pready both straight from flops
  wire pready_d = access && !pready_q;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RESET_VALUE;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pready_d && !mapped;
      prdata_q <= (pready_d && !I_APB.pwrite) ? rd_mux : RESET_VALUE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      ctrl_q <= RESET_VALUE;
      pos_q <= RESET_VALUE;
      wb_q <= RESET_VALUE;
      base_q <= RESET_VALUE;
      col_q <= {4{RESET_VALUE}};
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_q <= I_APB.pwdata & CTRL_MASK;
      if (sel_pos) pos_q <= I_APB.pwdata & POS_MASK;
      if (sel_wb) wb_q <= I_APB.pwdata & WB_MASK;
      if (sel_base) base_q <= I_APB.pwdata;
      for (int i = 0; i < 4; i++) begin
        if (sel_col[i]) col_q[i] <= I_APB.pwdata & COL_MASK;
      end
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;

  // ****************************************************************
  // field decode and geometry
  // ****************************************************************
  wire [2:0] mode = ctrl_q[MODE_LSB +: 3];
  wire [10:0] bitmap_tip_col = ctrl_q[COLF_LSB +: FIELD_W];
  wire [10:0] bitmap_tip_row = ctrl_q[ROWF_LSB +: FIELD_W];
  wire [10:0] screen_tip_col = pos_q[COLF_LSB +: FIELD_W];
  wire [10:0] screen_tip_row = pos_q[ROWF_LSB +: FIELD_W];
  wire [10:0] line_word_offset = wb_q[COLF_LSB +: FIELD_W];
  wire [10:0] line_fetch_length = wb_q[ROWF_LSB +: FIELD_W];
  wire [31:0] cursor_fetch_base = base_q;
  wire mode_ok = (mode <= MODE_128_1T);
  wire is_1bpp = (mode == MODE_128_2C) || (mode == MODE_128_1T);
  wire [11:0] side = (mode == MODE_32_4C || mode == MODE_32_3T) ? SIDE_32 :
                     (mode == MODE_64_4C || mode == MODE_64_3T) ? SIDE_64 :
                     SIDE_128;
  // corner may sit left of or above the screen; the 12-bit wrap in dx and dy still places it
  wire [11:0] left = {1'b0, screen_tip_col} - {1'b0, bitmap_tip_col};
  wire [11:0] top = {1'b0, screen_tip_row} - {1'b0, bitmap_tip_row};
  wire [11:0] dy = {1'b0, I_LINE_Y} - top;
  wire [11:0] dx = {1'b0, I_PIX_X} - left;
  wire row_in = (dy < side);
  wire col_in = (dx < side);

  // ****************************************************************
  // line fetch
  // ****************************************************************
  hco_fetch_e state_q, state_d;
  logic [10:0] cnt_q;
  logic [31:0] mem_addr_q;
  logic mem_req_q, hit_q;
  logic [BUF_WORDS-1:0][31:0] line_q;

  wire [17:0] row_words = dy[6:0] * line_word_offset;
  wire [31:0] line_addr = cursor_fetch_base + {12'h000, row_words, 2'b00};
  wire idle = (state_q == FETCH_IDLE);
  wire line_ok = row_in && mode_ok && (line_fetch_length != 11'h000);
  // a line start that finds a fetch still running is dropped
  wire start = I_LINE_START && idle && line_ok;
  wire take = mem_req_q && I_MEM_ACK;
  wire last = (cnt_q == line_fetch_length - 11'h001);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FETCH_IDLE: if (start) state_d = FETCH_RUN;
      FETCH_RUN: if (take && last) state_d = FETCH_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      state_q <= FETCH_IDLE;
      mem_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mem_req_q <= (state_d == FETCH_RUN);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      cnt_q <= 11'h000;
      mem_addr_q <= RESET_VALUE;
      hit_q <= 1'b0;
    end else begin
      if (I_LINE_START) hit_q <= idle && line_ok;
      if (start) begin
        cnt_q <= 11'h000;
        mem_addr_q <= line_addr;
      end else if (take) begin
        cnt_q <= cnt_q + 11'h001;
        mem_addr_q <= mem_addr_q + WORD_BYTES;
      end
    end
  end

  // words past the buffer are fetched but dropped: 128 pixels fit in 8
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      line_q <= {BUF_WORDS{RESET_VALUE}};
    end else if (take && (cnt_q < 11'(BUF_WORDS))) begin
      line_q[cnt_q[2:0]] <= I_MEM_RDATA;
    end
  end

  assign O_MEM_REQ = mem_req_q;
  assign O_MEM_ADDR = mem_addr_q;
  assign status_word = {14'h0000, !idle, hit_q, 5'h00, cnt_q};

  // ****************************************************************
  // pixel overlay
  // ****************************************************************
  // data shows only once fetched; start the line well before its pixels
  wire [255:0] line_flat = line_q;
  wire [7:0] bit_lo = is_1bpp ? {1'b0, dx[6:0]} : {dx[6:0], 1'b0};
  wire [7:0] bit_hi = {dx[6:0], 1'b1};
  wire [1:0] code = is_1bpp ? {1'b0, line_flat[bit_lo]} :
                    {line_flat[bit_hi], line_flat[bit_lo]};
  wire [3:0][23:0] colours = {col_q[3][23:0], col_q[2][23:0],
                              col_q[1][23:0], col_q[0][23:0]};
  hco_rgb_s cur_rgb;
  logic opaque;

  hco_palette u_palette (
    .i_mode(mode),
    .i_code(code),
    .i_colours(colours),
    .o_rgb(cur_rgb),
    .o_opaque(opaque)
  );

  wire draw = I_PIX_VALID && hit_q && col_in && opaque;
  hco_rgb_s pix_q;
  logic pix_valid_q, cursor_hit_q;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      pix_q <= '0;
      pix_valid_q <= 1'b0;
      cursor_hit_q <= 1'b0;
    end else begin
      pix_q <= draw ? cur_rgb : I_VIDEO_RGB;
      pix_valid_q <= I_PIX_VALID;
      cursor_hit_q <= draw;
    end
  end

  assign O_PIX_RGB = pix_q;
  assign O_PIX_VALID = pix_valid_q;
  assign O_CURSOR_HIT = cursor_hit_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence last_word_s;
    mem_req_q && I_MEM_ACK && last;
  endsequence
  sequence line_go_s;
    I_LINE_START && idle && line_ok;
  endsequence

  // fetch engine
  fetch_len_a: assert property (
    last_word_s |=> !mem_req_q && cnt_q == $past(line_fetch_length))
    else $error("fetch did not end after the programmed word count");

  fetch_more_a: assert property (
    mem_req_q && I_MEM_ACK && !last |=> mem_req_q)
    else $error("fetch ended early");

  fetch_step_a: assert property (
    take && !start |=> O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h4)
    else $error("fetch address did not step one word");

  fetch_base_a: assert property (
    line_go_s |=> O_MEM_ADDR == $past(cursor_fetch_base) + {12'h000, $past(row_words), 2'b00}
    ##1 O_MEM_REQ)
    else $error("line fetch did not start at base plus stride");

  // undefined formats must not touch memory at all
  mode_bad_a: assert property (
    I_LINE_START && idle && !mode_ok |=> !O_MEM_REQ && !hit_q)
    else $error("line fetched in an undefined mode");

  // pixel path
  side_max_a: assert property (
    draw |-> dx < 12'h080 && (is_1bpp || dx < 12'h040) && (mode > MODE_32_3T || dx < 12'h020))
    else $error("cursor drawn outside its block");

  // worked from the raw fields, not from dx, so a bad corner shows
  corner_a: assert property (
    draw |-> 12'({1'b0, I_PIX_X} + {1'b0, bitmap_tip_col} - {1'b0, screen_tip_col}) < side)
    else $error("cursor corner not at tip minus offset");

  trans_a: assert property (
    I_PIX_VALID && (mode == MODE_32_3T || mode == MODE_64_3T) && code == 2'h3
    |=> O_PIX_RGB == $past(I_VIDEO_RGB) && !O_CURSOR_HIT)
    else $error("colour three shown in transparency mode");

  clear_code_a: assert property (
    I_PIX_VALID && mode == MODE_128_1T && code == 2'h0 |=> !O_CURSOR_HIT)
    else $error("clear pixel drawn in the one colour mode");

  colour_a: assert property (
    draw |=> O_PIX_RGB == $past(col_q[code][23:0]) && O_CURSOR_HIT)
    else $error("cursor pixel not from its colour register");

  // register bus
  pos_wr_a: assert property (
    wr_en && sel_pos |=> pos_q == ($past(I_APB.pwdata) & 32'h07FF_07FF))
    else $error("screen position write lost");

  ctrl_wr_a: assert property (
    wr_en && sel_ctrl |=> mode == $past(I_APB.pwdata[2:0]) &&
    bitmap_tip_row == $past(I_APB.pwdata[26:16]))
    else $error("control write lost");

  apb_wait_a: assert property (
    access && !pready_q |=> O_PREADY ##1 !O_PREADY)
    else $error("apb answer not one wait state");

endmodule : hco_cursor
`default_nettype wire

/* verification/hco_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// cursor bitmap store, random latency per word
// ****************************************************************
module hco_mem_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [1:0] wait_q;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      wait_q <= 2'h0;
    end else if (i_req && !o_ack && wait_q == 2'h0) begin
      o_ack <= 1'b1;
      o_rdata <= i_addr ^ 32'hA5C3_5A3C;
      wait_q <= 2'($urandom_range(3));
    end else begin
      o_ack <= 1'b0;
      // stale data toggles so it never passes as a fresh word
      o_rdata <= ~o_rdata;
      if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
    end
  end
endmodule : hco_mem_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hco_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  hco_apb_req_s apb = '0;
  logic [31:0] prdata, maddr, mdata, rd, ea;
  logic pready, pslverr, mreq, mack, ovld, hit, err;
  logic ls = 1'b0;
  logic pv = 1'b0;
  logic [10:0] ly = '0;
  logic [10:0] px = '0;
  hco_rgb_s vid = '0;
  hco_rgb_s orgb;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nack = 0;
  logic [31:0] ew;
  logic [31:0] exp_q [$];
  logic [31:0] regs [8];
  always #5 clk = ~clk;
  hco_cursor uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_APB(apb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LINE_START(ls), .I_LINE_Y(ly),
    .I_PIX_VALID(pv), .I_PIX_X(px), .I_VIDEO_RGB(vid), .O_PIX_RGB(orgb),
    .O_PIX_VALID(ovld), .O_CURSOR_HIT(hit), .O_MEM_REQ(mreq), .O_MEM_ADDR(maddr),
    .I_MEM_ACK(mack), .I_MEM_RDATA(mdata));
  hco_mem_model mem (.i_clk(clk), .i_nrst(nrst), .i_req(mreq), .i_addr(maddr),
    .o_ack(mack), .o_rdata(mdata));
  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  always @(posedge clk) begin
    if (mreq && mack) begin
      ew = 32'hFFFF_FFFF;
      if (exp_q.size() > 0) ew = exp_q.pop_front();
      chk(maddr, ew);
      nack++;
    end
  end
  // ****************************************************************
  // apb master, holds request until pready sampled high
  // ****************************************************************
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    apb <= '0;
    chk(32'(n < 20), 32'h1);
  endtask : bus
  function automatic logic [31:0] msk(input int i);
    return i == 0 ? CTRL_MASK : i == 1 ? POS_MASK : i == 2 ? WB_MASK :
      i == 3 ? 32'hFFFF_FFFF : COL_MASK;
  endfunction : msk
  // ****************************************************************
  // one cursor line per mode: fetch then pixel sweep
  // ****************************************************************
  task automatic run_mode(input int m);
    int sd, tx, ty, x0, y0, row, st, k, code, eh, cx;
    logic [31:0] w [4];
    logic [23:0] col [4];
    logic [23:0] er;
    sd = m < 2 ? 32 : m < 4 ? 64 : 128;
    tx = 8 * ($urandom % (sd / 8)) + m;
    ty = $urandom % sd;
    x0 = 300 + $urandom % 200;
    y0 = 300 + $urandom % 200;
    row = $urandom % sd;
    st = $urandom % 16;
    ea = $urandom & 32'hFFFF_FF00;
    bus(1'b1, ADDR_CTRL, 32'((ty << 16) | tx));
    bus(1'b1, ADDR_POS, 32'((y0 << 16) | x0));
    bus(1'b1, ADDR_WB, 32'((4 << 16) | st));
    bus(1'b1, ADDR_BASE, ea);
    for (int i = 0; i < 4; i++) begin
      col[i] = 24'($urandom);
      bus(1'b1, ADDR_COL0 + 32'(4 * i), {8'h0, col[i]});
    end
    ea = ea + 32'(row * st * 4);
    for (int i = 0; i < 4; i++) begin
      w[i] = (ea + 32'(4 * i)) ^ 32'hA5C3_5A3C;
      exp_q.push_back(ea + 32'(4 * i));
    end
    nack = 0;
    @(posedge clk);
    ls <= 1'b1;
    ly <= 11'(y0 - ty + row);
    @(posedge clk);
    ls <= 1'b0;
    repeat (60) @(posedge clk);
    chk(32'(nack), 32'h4);
    chk(32'(exp_q.size()), 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0001_0004);
    cx = x0 - tx;
    eh = 0;
    er = '0;
    for (int x = cx - 2; x <= cx + sd + 2; x++) begin
      @(posedge clk);
      pv <= 1'b1;
      px <= 11'(x);
      vid <= 24'($urandom);
      #1;
      if (x > cx - 2) begin
        chk(32'(hit), 32'(eh));
        chk(32'(orgb), 32'(er));
        chk(32'(ovld), 32'h1);
      end
      k = x - cx;
      code = 0;
      if (k >= 0 && k < sd) begin
        if (m < 4) code = int'((w[k / 16] >> (2 * (k % 16))) & 32'h3);
        else code = int'((w[k / 32] >> (k % 32)) & 32'h1);
      end
      eh = k >= 0 && k < sd && !((m == 1 || m == 3) && code == 3) && !(m == 5 && code == 0);
      er = eh ? col[code] : vid;
    end
    pv <= 1'b0;
    $display("mode %0d done", m);
  endtask : run_mode
  initial begin
    rd = $urandom(73);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ADDR_CTRL + 32'(4 * i), 32'h0);
      chk(rd, RESET_VALUE);
    end
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      regs[i] = $urandom;
      bus(1'b1, ADDR_CTRL + 32'(4 * i), regs[i]);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ADDR_CTRL + 32'(4 * i), 32'h0);
      chk(rd, regs[i] & msk(i));
      chk(32'(err), 32'h0);
    end
    bus(1'b0, 32'hB000_8090, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("register access done");
    for (int m = 0; m < 6; m++) run_mode(m);
    // mode 6 with a row inside the block: nothing fetched, nothing drawn
    bus(1'b1, ADDR_CTRL, 32'h0000_0006);
    bus(1'b1, ADDR_POS, 32'h0000_0010);
    nack = 0;
    @(posedge clk);
    ls <= 1'b1;
    ly <= 11'h000;
    @(posedge clk);
    ls <= 1'b0;
    pv <= 1'b1;
    px <= 11'h014;
    vid <= 24'($urandom);
    @(posedge clk);
    pv <= 1'b0;
    #1;
    chk(32'(hit), 32'h0);
    chk(32'(orgb), 32'(vid));
    repeat (30) @(posedge clk);
    chk(32'(nack), 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h0003_0000, 32'h0);
    $display("undefined mode done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
